// *** sim/test_bwop_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_bwop_datapath;
  // ----------------------------------------
  // Stimulus and observed results
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  bwop_pkg::bwop_op_e opSel = bwop_pkg::BWOP_ADD;
  logic [7:0] opA = 8'h00;
  logic [7:0] opB = 8'h00;
  logic [3:0] shiftCount = 4'h0;
  logic [3:0] condValue = 4'h0;
  logic memWrEn = 1'b0;
  logic [1:0] memWrAddr = 2'h0;
  logic [7:0] memWrData = 8'h00;
  logic [1:0] memRdAddr = 2'h0;
  logic [7:0] result_ff;
  logic [3:0] take_ff;
  logic [3:0] drop_ff;
  logic [15:0] join_ff;
  logic [4:0] range_ff;
  logic bit_ff;
  bwop_pkg::bwop_cmp_s cmp_ff;
  logic mixGt_ff;
  logic [4:0] memField_ff;
  logic memBit_ff;
  logic [7:0] sgnResult;
  bwop_pkg::bwop_cmp_s sgnCmp;
  logic sgnMixGt;
  int err_count = 0;
  int comparisons = 0;

  always #12.5 core_clk = ~core_clk;

  bwop_datapath i_bwop_datapath (
    .core_clk(core_clk), .rst_n(rst_n), .opSel(opSel), .opA(opA),
    .opB(opB), .shiftCount(shiftCount), .condValue(condValue),
    .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .memRdAddr(memRdAddr), .result_ff(result_ff), .take_ff(take_ff),
    .drop_ff(drop_ff), .join_ff(join_ff), .range_ff(range_ff),
    .bit_ff(bit_ff), .cmp_ff(cmp_ff), .mixGt_ff(mixGt_ff),
    .memField_ff(memField_ff), .memBit_ff(memBit_ff)
  );

  // Signed build on the same stimulus
  bwop_datapath #(.SIGNED_OPS(1'b1)) i_bwop_datapath_signed (
    .core_clk(core_clk), .rst_n(rst_n), .opSel(opSel), .opA(opA),
    .opB(opB), .shiftCount(shiftCount), .condValue(condValue),
    .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .memRdAddr(memRdAddr), .result_ff(sgnResult), .take_ff(),
    .drop_ff(), .join_ff(), .range_ff(), .bit_ff(), .cmp_ff(sgnCmp),
    .mixGt_ff(sgnMixGt), .memField_ff(), .memBit_ff()
  );

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs change 1 ns after an edge; result lands one edge later
  task automatic run(input bwop_pkg::bwop_op_e s, input logic [7:0] a,
                     input logic [7:0] b, input logic [3:0] n,
                     input logic [3:0] c);
    opSel = s;
    opA = a;
    opB = b;
    shiftCount = n;
    condValue = c;
    @(posedge core_clk);
    #1;
  endtask

  task automatic rc(input bwop_pkg::bwop_op_e s, input logic [7:0] a,
                    input logic [7:0] b, input logic [3:0] n,
                    input logic [3:0] c, input logic [7:0] exp);
    run(s, a, b, n, c);
    check({8'h00, result_ff}, {8'h00, exp});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_arith();
    rc(bwop_pkg::BWOP_ADD, 8'h80, 8'hc0, 4'h0, 4'h0, 8'h40);
    rc(bwop_pkg::BWOP_MUL, 8'h02, 8'hc0, 4'h0, 4'h0, 8'h80);
    rc(bwop_pkg::BWOP_SUB, 8'h05, 8'h07, 4'h0, 4'h0, 8'hfe);
    rc(bwop_pkg::BWOP_DIV, 8'hc8, 8'h07, 4'h0, 4'h0, 8'h1c);
    rc(bwop_pkg::BWOP_MOD, 8'hc8, 8'h07, 4'h0, 4'h0, 8'h04);
    rc(bwop_pkg::BWOP_DIV, 8'h33, 8'h00, 4'h0, 4'h0, 8'h00);
    rc(bwop_pkg::BWOP_MOD, 8'h33, 8'h00, 4'h0, 4'h0, 8'h33);
  endtask

  task automatic t_shift();
    rc(bwop_pkg::BWOP_SHL, 8'h81, 8'h00, 4'h1, 4'h0, 8'h02);
    rc(bwop_pkg::BWOP_SHL, 8'hff, 8'h00, 4'h7, 4'h0, 8'h80);
    rc(bwop_pkg::BWOP_SHL, 8'hff, 8'h00, 4'h8, 4'h0, 8'h00);
    rc(bwop_pkg::BWOP_SHR, 8'h0d, 8'h00, 4'h2, 4'h0, 8'h03);
    rc(bwop_pkg::BWOP_SHR, 8'hf0, 8'h00, 4'h8, 4'h0, 8'h00);
  endtask

  task automatic t_bits();
    run(bwop_pkg::BWOP_AND, 8'hc7, 8'h3c, 4'h0, 4'h0);
    check({12'h000, take_ff}, 16'h0007);
    check({12'h000, drop_ff}, 16'h000c);
    check(join_ff, 16'hc73c);
    run(bwop_pkg::BWOP_AND, 8'h59, 8'h00, 4'h0, 4'h0);
    check({15'h0000, bit_ff}, 16'h0001);
    check({11'h000, range_ff}, 16'h000b);
    check({12'h000, take_ff}, 16'h0009);
  endtask

  task automatic t_cmp();
    run(bwop_pkg::BWOP_ADD, 8'h01, 8'hff, 4'h0, 4'h0);
    check({10'h000, cmp_ff}, {10'h000, 6'b011010});
    check({15'h0000, mixGt_ff}, 16'h0001);
    check({10'h000, sgnCmp}, {10'h000, 6'b010101});
    check({15'h0000, sgnMixGt}, 16'h0000);
    run(bwop_pkg::BWOP_ADD, 8'h7f, 8'h7f, 4'h0, 4'h0);
    check({10'h000, cmp_ff}, {10'h000, 6'b100011});
    check({15'h0000, mixGt_ff}, 16'h0000);
    check({10'h000, sgnCmp}, {10'h000, 6'b100011});
    run(bwop_pkg::BWOP_ADD, 8'h80, 8'h01, 4'h0, 4'h0);
    check({10'h000, cmp_ff}, {10'h000, 6'b010101});
    check({10'h000, sgnCmp}, {10'h000, 6'b011010});
    run(bwop_pkg::BWOP_ADD, 8'h05, 8'h03, 4'h0, 4'h0);
    check({10'h000, cmp_ff}, {10'h000, 6'b010101});
    check({15'h0000, mixGt_ff}, 16'h0001);
    check({15'h0000, sgnMixGt}, 16'h0001);
  endtask

  // Sign fill and full-width count on both builds, signed divide on the signed one
  task automatic t_signed();
    run(bwop_pkg::BWOP_SHR, 8'hf4, 8'h00, 4'h1, 4'h0);
    check({8'h00, result_ff}, 16'h007a);
    check({8'h00, sgnResult}, 16'h00fa);
    run(bwop_pkg::BWOP_SHR, 8'h90, 8'h00, 4'h8, 4'h0);
    check({8'h00, result_ff}, 16'h0000);
    check({8'h00, sgnResult}, 16'h00ff);
    run(bwop_pkg::BWOP_DIV, 8'hc8, 8'h07, 4'h0, 4'h0);
    check({8'h00, sgnResult}, 16'h00f8);
    run(bwop_pkg::BWOP_MOD, 8'hc9, 8'h07, 4'h0, 4'h0);
    check({8'h00, result_ff}, 16'h0005);
    check({8'h00, sgnResult}, 16'h00fa);
  endtask

  task automatic t_logic();
    rc(bwop_pkg::BWOP_AND, 8'hac, 8'h35, 4'h0, 4'h0, 8'h24);
    rc(bwop_pkg::BWOP_OR, 8'hac, 8'h35, 4'h0, 4'h0, 8'hbd);
    rc(bwop_pkg::BWOP_XOR, 8'hac, 8'h35, 4'h0, 4'h0, 8'h99);
    rc(bwop_pkg::BWOP_NOT, 8'hac, 8'h35, 4'h0, 4'h0, 8'h53);
    rc(bwop_pkg::BWOP_LAND, 8'h10, 8'h02, 4'h0, 4'h0, 8'h01);
    rc(bwop_pkg::BWOP_LAND, 8'h10, 8'h00, 4'h0, 4'h0, 8'h00);
    rc(bwop_pkg::BWOP_LOR, 8'h00, 8'h40, 4'h0, 4'h0, 8'h01);
    rc(bwop_pkg::BWOP_LOR, 8'h00, 8'h00, 4'h0, 4'h0, 8'h00);
    rc(bwop_pkg::BWOP_LNOT, 8'h20, 8'h00, 4'h0, 4'h0, 8'h00);
    rc(bwop_pkg::BWOP_LNOT, 8'h00, 8'h00, 4'h0, 4'h0, 8'h01);
    rc(bwop_pkg::BWOP_SEL, 8'h11, 8'h22, 4'h0, 4'h8, 8'h11);
    rc(bwop_pkg::BWOP_SEL, 8'h11, 8'h22, 4'h0, 4'h0, 8'h22);
  endtask

  task automatic t_mem();
    memWrEn = 1'b1;
    memWrAddr = 2'h1;
    memWrData = 8'hc7;
    @(posedge core_clk);
    #1;
    memWrAddr = 2'h2;
    memWrData = 8'h10;
    memRdAddr = 2'h1;
    @(posedge core_clk);
    #1;
    check({10'h000, memField_ff, memBit_ff}, 16'h0030);
    // Same-cycle read of the word being written gives the old word
    memWrAddr = 2'h1;
    @(posedge core_clk);
    #1;
    memWrEn = 1'b0;
    check({10'h000, memField_ff, memBit_ff}, 16'h0030);
    @(posedge core_clk);
    #1;
    check({10'h000, memField_ff, memBit_ff}, 16'h0005);
    // One more edge so the read-after-write check completes
    @(posedge core_clk);
    #1;
    check({10'h000, memField_ff, memBit_ff}, 16'h0005);
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic summarize();
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    check({8'h00, result_ff}, 16'h0000);
    rst_n = 1'b1;
    // Two sync stages: first usable edge is the third after release
    repeat (2) @(posedge core_clk);
    #1;
    t_arith();
    t_shift();
    t_bits();
    t_cmp();
    t_logic();
    t_signed();
    t_mem();
    summarize();
  end
endmodule

`default_nettype wire

// *** src/bwop_datapath.sv ***
// Notes on behaviour
// RL1 - Shift result keeps operand width; bits shifted out are discarded.
// RL2 - Right shift fills zeros if unsigned, copies of top bit if signed.
// RL3 - Shift count is ceiling_log_two(width+1) bits wide.
// RL4 - Take gives n low bits, drop gives the rest; n fixed.
// RL5 - Join width is sum of widths; left operand is upper part.
// RL6 - Bit 0 is least significant; ranges are upper:lower, inclusive, fixed.
// RL7 - Stored words give bit ranges on read; writes are whole words only.
// RL8 - Width query is an elaboration constant sizing extractions.
// RL9 - Arithmetic operands share one width and one signedness.
// RL10 - Arithmetic results keep operand width; overflow is dropped.
// RL11 - Comparisons give a one-bit flag, zero-extended before arithmetic.
// RL12 - Mixed-sign compare only after one-bit extension to common signed form.
// RL13 - A multi-bit condition means value not equal to zero.
// RL14 - Logical and, or, not work on one-bit values, wider ones tested.
// RL15 - Bitwise operators keep operand width and signedness.
// RL16 - Selector gives second operand if true, else third; widths match.
// RL17 - Every operator is combinational, registered in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module bwop_datapath #(
  parameter int W = bwop_pkg::DATA_W,
  parameter bit SIGNED_OPS = bwop_pkg::OPS_SIGNED,
  parameter int TAKE_N = bwop_pkg::TAKE_N,
  parameter int RANGE_HI = bwop_pkg::RANGE_HI,
  parameter int RANGE_LO = bwop_pkg::RANGE_LO,
  parameter int BIT_SEL = bwop_pkg::BIT_SEL,
  parameter int COND_W = bwop_pkg::COND_W,
  parameter int MEM_DEPTH = bwop_pkg::MEM_DEPTH,
  parameter int SH_W = bwop_pkg::ceiling_log_two(W + 1),
  parameter int MA_W = bwop_pkg::ceiling_log_two(MEM_DEPTH)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Operation and operands
  input wire bwop_pkg::bwop_op_e opSel,
  input wire logic [W-1:0] opA,
  input wire logic [W-1:0] opB,
  input wire logic [SH_W-1:0] shiftCount,
  input wire logic [COND_W-1:0] condValue,
  // Word store
  input wire logic memWrEn,
  input wire logic [MA_W-1:0] memWrAddr,
  input wire logic [W-1:0] memWrData,
  input wire logic [MA_W-1:0] memRdAddr,
  // Results
  output logic [W-1:0] result_ff,
  output logic [TAKE_N-1:0] take_ff,
  output logic [W-TAKE_N-1:0] drop_ff,
  output logic [2*W-1:0] join_ff,
  output logic [RANGE_HI-RANGE_LO:0] range_ff,
  output logic bit_ff,
  output bwop_pkg::bwop_cmp_s cmp_ff,
  output logic mixGt_ff,
  output logic [RANGE_HI-RANGE_LO:0] memField_ff,
  output logic memBit_ff
);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic [bwop_pkg::RST_STAGES-1:0] rstPipe_ff;
  logic rstSyncN;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_ff <= '0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[bwop_pkg::RST_STAGES-2:0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe_ff[bwop_pkg::RST_STAGES-1];

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Wide value reduced to a one-bit truth value
  function automatic logic nonZero(input logic [W-1:0] v);
    return v != '0; // RL13
  endfunction

  // One-bit flag zero-extended to operand width
  function automatic logic [W-1:0] widenFlag(input logic f);
    return {{(W-1){1'b0}}, f}; // RL11
  endfunction

  // ------------------------------------------------------------------
  // Shifter
  // ------------------------------------------------------------------
  // Count width covers zero up to the full width
  logic [W-1:0] shiftOut; // RL3

  bwop_shifter #(
    .W(W),
    .SIGNED_OPS(SIGNED_OPS),
    .SH_W(SH_W)
  ) u_shifter (
    .value(opA),
    .amount(shiftCount),
    .toRight(opSel == bwop_pkg::BWOP_SHR),
    .shifted(shiftOut)
  );

  // ------------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------------
  // One signedness parameter covers both operands, so a mismatched
  // pairing cannot be built
  logic isLt;
  logic isGt;
  logic [W:0] extA;
  logic [W:0] extB;
  logic nxt_mixGt;
  bwop_pkg::bwop_cmp_s nxt_cmp;

  always_comb begin
    if (SIGNED_OPS) begin
      isLt = $signed(opA) < $signed(opB); // RL12
      isGt = $signed(opA) > $signed(opB); // RL12
    end else begin
      isLt = opA < opB; // RL12
      isGt = opA > opB; // RL12
    end
    nxt_cmp.eq = opA == opB; // RL11
    nxt_cmp.ne = opA != opB;
    nxt_cmp.lt = isLt;
    nxt_cmp.gt = isGt;
    nxt_cmp.le = !isGt;
    nxt_cmp.ge = !isLt;
  end

  // Operand B read with the opposite signedness; both sides widened
  // by one bit so the signed compare is exact
  always_comb begin
    if (SIGNED_OPS) begin
      extA = {opA[W-1], opA}; // RL12
      extB = {1'b0, opB}; // RL12
    end else begin
      extA = {1'b0, opA}; // RL12
      extB = {opB[W-1], opB}; // RL12
    end
    nxt_mixGt = $signed(extA) > $signed(extB); // RL12
  end

  // ------------------------------------------------------------------
  // Operator select
  // ------------------------------------------------------------------
  logic [W-1:0] nxt_result;
  logic condTrue;

  assign condTrue = condValue != '0; // RL13

  always_comb begin
    nxt_result = '0;
    unique case (opSel)
      bwop_pkg::BWOP_ADD: nxt_result = opA + opB; // RL10
      bwop_pkg::BWOP_SUB: nxt_result = opA - opB; // RL10
      bwop_pkg::BWOP_MUL: nxt_result = opA * opB; // RL10
      bwop_pkg::BWOP_DIV: begin
        // Zero divisor gives zero rather than an undefined value
        if (opB == '0) begin
          nxt_result = '0;
        end else if (SIGNED_OPS) begin
          nxt_result = W'($signed(opA) / $signed(opB)); // RL9
        end else begin
          nxt_result = opA / opB; // RL9
        end
      end
      bwop_pkg::BWOP_MOD: begin
        if (opB == '0) begin
          nxt_result = opA;
        end else if (SIGNED_OPS) begin
          nxt_result = W'($signed(opA) % $signed(opB)); // RL9
        end else begin
          nxt_result = opA % opB; // RL9
        end
      end
      bwop_pkg::BWOP_AND: nxt_result = opA & opB; // RL15
      bwop_pkg::BWOP_OR: nxt_result = opA | opB; // RL15
      bwop_pkg::BWOP_XOR: nxt_result = opA ^ opB; // RL15
      bwop_pkg::BWOP_NOT: nxt_result = ~opA; // RL15
      bwop_pkg::BWOP_SHL: nxt_result = shiftOut; // RL1
      bwop_pkg::BWOP_SHR: nxt_result = shiftOut; // RL2
      bwop_pkg::BWOP_LAND: begin
        nxt_result = widenFlag(nonZero(opA) && nonZero(opB)); // RL14
      end
      bwop_pkg::BWOP_LOR: begin
        nxt_result = widenFlag(nonZero(opA) || nonZero(opB)); // RL14
      end
      bwop_pkg::BWOP_LNOT: nxt_result = widenFlag(!nonZero(opA)); // RL14
      bwop_pkg::BWOP_SEL: nxt_result = condTrue ? opA : opB; // RL16
      default: nxt_result = '0;
    endcase
  end

  // ------------------------------------------------------------------
  // Word store
  // ------------------------------------------------------------------
  // Whole words only; no partial write path exists
  logic [W-1:0] memWord [MEM_DEPTH];
  logic [W-1:0] memRdWord;

  always_ff @(posedge core_clk) begin
    if (memWrEn) begin
      memWord[memWrAddr] <= memWrData; // RL7
    end
  end

  assign memRdWord = memWord[memRdAddr];

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      memField_ff <= '0;
      memBit_ff <= 1'b0;
    end else begin
      memField_ff <= memRdWord[RANGE_HI:RANGE_LO]; // RL7
      memBit_ff <= memRdWord[BIT_SEL]; // RL7
    end
  end

  // ------------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      result_ff <= '0;
      cmp_ff <= '0;
      mixGt_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result; // RL17
      cmp_ff <= nxt_cmp; // RL17
      mixGt_ff <= nxt_mixGt; // RL17
    end
  end

  // Slice sizes follow the destination width at elaboration
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      take_ff <= '0;
      drop_ff <= '0;
      join_ff <= '0;
      range_ff <= '0;
      bit_ff <= 1'b0;
    end else begin
      take_ff <= opA[$bits(take_ff)-1:0]; // RL8
      drop_ff <= opA[W-1:TAKE_N]; // RL4
      join_ff <= {opA, opB}; // RL5
      range_ff <= opA[RANGE_HI:RANGE_LO]; // RL6
      bit_ff <= opA[BIT_SEL]; // RL6
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Checks arm one edge after outputs leave reset, so reset values
  // are never judged as results
  logic chkArmed_ff;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      chkArmed_ff <= 1'b0;
    end else begin
      chkArmed_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!chkArmed_ff);

  chk_shift_discard: assert property ( // RL1
    (opSel == bwop_pkg::BWOP_SHL && shiftCount >= W) |=> result_ff == '0)
    else $error("Left shift past width kept bits");

  chk_shift_fill: assert property ( // RL2
    (opSel == bwop_pkg::BWOP_SHR && shiftCount == 1)
    |=> result_ff[W-1] == (SIGNED_OPS && $past(opA[W-1]))
        && result_ff[W-2:0] == $past(opA[W-1:1]))
    else $error("Right shift fill wrong");

  chk_take_drop: assert property ( // RL4
    1'b1 |=> {drop_ff, take_ff} == $past(opA))
    else $error("Take and drop do not rebuild operand");

  chk_join_order: assert property ( // RL5
    1'b1 |=> join_ff[2*W-1:W] == $past(opA) && join_ff[W-1:0] == $past(opB))
    else $error("Join order wrong");

  chk_range_sel: assert property ( // RL6
    1'b1 |=> range_ff == $past(opA >> RANGE_LO)
             && bit_ff == $past(opA[BIT_SEL]))
    else $error("Bit or range select wrong");

  chk_mem_read: assert property ( // RL7
    (memWrEn && memWrAddr == memRdAddr)
    ##1 (memRdAddr == $past(memWrAddr))
    |=> memField_ff == $past(memWrData[RANGE_HI:RANGE_LO], 2))
    else $error("Stored word range read wrong");

  chk_add_wrap: assert property ( // RL10
    (opSel == bwop_pkg::BWOP_ADD) |=> result_ff == W'($past(opA) + $past(opB)))
    else $error("Addition not wrapped to width");

  chk_cmp_flags: assert property ( // RL11
    1'b1 |=> (cmp_ff.eq ^ cmp_ff.ne) && (cmp_ff.lt ^ cmp_ff.ge)
             && ($countones({cmp_ff.lt, cmp_ff.eq, cmp_ff.gt}) == 1)
             && cmp_ff.eq == ($past(opA) == $past(opB)))
    else $error("Compare flags inconsistent");

  chk_logic_and: assert property ( // RL14
    (opSel == bwop_pkg::BWOP_LAND)
    |=> result_ff == widenFlag($past(opA) != '0 && $past(opB) != '0))
    else $error("Logical and wrong");

  chk_cond_sel: assert property ( // RL16
    (opSel == bwop_pkg::BWOP_SEL)
    |=> result_ff == ($past(condValue) != '0 ? $past(opA) : $past(opB)))
    else $error("Selector picked wrong operand");

endmodule

`default_nettype wire

// *** src/bwop_pkg.sv ***
`default_nettype none

package bwop_pkg;

  // ------------------------------------------------------------------
  // Elaboration defaults
  // ------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int TAKE_N = 4;
  localparam int RANGE_HI = 7;
  localparam int RANGE_LO = 3;
  localparam int BIT_SEL = 4;
  localparam int COND_W = 4;
  localparam int MEM_DEPTH = 4;
  localparam bit OPS_SIGNED = 1'b0;
  localparam int RST_STAGES = 2;

  // ------------------------------------------------------------------
  // Operations
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    BWOP_ADD, BWOP_SUB, BWOP_MUL, BWOP_DIV, BWOP_MOD,
    BWOP_AND, BWOP_OR, BWOP_XOR, BWOP_NOT,
    BWOP_SHL, BWOP_SHR,
    BWOP_LAND, BWOP_LOR, BWOP_LNOT,
    BWOP_SEL
  } bwop_op_e;

  typedef struct packed {
    logic eq;
    logic ne;
    logic lt;
    logic gt;
    logic le;
    logic ge;
  } bwop_cmp_s;

  // Smallest r with 2**r >= n
  function automatic int ceiling_log_two(input int n);
    int r;
    r = 0;
    for (int i = 0; i < 31; i++) begin
      if ((1 << i) < n) begin
        r = i + 1;
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// *** src/bwop_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none

module bwop_shifter #(
  parameter int W = bwop_pkg::DATA_W,
  parameter bit SIGNED_OPS = bwop_pkg::OPS_SIGNED,
  parameter int SH_W = bwop_pkg::ceiling_log_two(W + 1)
) (
  // Operand and count
  input wire logic [W-1:0] value,
  input wire logic [SH_W-1:0] amount,
  input wire logic toRight,
  // Result
  output logic [W-1:0] shifted
);

  // Result keeps the operand width; bits pushed out are lost
  always_comb begin
    if (!toRight) begin
      shifted = value << amount; // RL1
    end else if (SIGNED_OPS) begin
      shifted = W'($signed(value) >>> amount); // RL2
    end else begin
      shifted = value >> amount; // RL2
    end
  end

endmodule

`default_nettype wire
